/* rtl/chlvl_pkg.sv */
`default_nettype none
package chlvl_pkg;
	// ***************************************************
	// Register map
	// ***************************************************
	localparam logic [7:0] ADDR_SOURCE_CONFIG  = 8'h41;
	localparam logic [7:0] ADDR_VOLUME         = 8'h43;
	localparam logic [7:0] ADDR_GAIN_TRIM      = 8'h44;
	localparam logic [7:0] ADDR_PHASE_DELAY    = 8'h45;
	localparam logic [7:0] RESET_SOURCE_CONFIG = 8'h00;
	localparam logic [7:0] RESET_VOLUME        = 8'hc9;
	localparam logic [7:0] RESET_GAIN_TRIM     = 8'h80;
	localparam logic [7:0] RESET_PHASE_DELAY   = 8'h00;
	// Writable bits of the source register: all but bit 1
	localparam logic [7:0] SOURCE_WRITE_MASK   = 8'hfd;
	localparam logic [7:0] TRIM_WRITE_MASK     = 8'hf0;
	localparam int         SOURCE_LSB          = 5;
	localparam int         TRIM_LSB            = 4;
	localparam logic [1:0] SOURCE_OFF          = 2'h0;
	localparam logic [1:0] SOURCE_MIC          = 2'h2;
	localparam logic [7:0] VOLUME_MUTE         = 8'h00;
	localparam logic [7:0] VOLUME_UNITY        = 8'hc9;
	localparam logic [3:0] TRIM_UNITY          = 4'h8;
	// Gains in tenths of a dB; volume is 5 per code, trim 1 per code
	localparam int         VOLUME_STEP_TENTHS  = 5;
	localparam int         TRIM_STEP_TENTHS    = 1;

	// ***************************************************
	// Carriers
	// ***************************************************
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} chlvl_req_type;

	typedef struct packed {
		logic              enable;
		logic              mute;
		logic [1:0]        source;
		logic [7:0]        volume;
		logic [3:0]        trim;
		logic [7:0]        delay;
		logic signed [11:0] gain_tenths_db;
	} chlvl_cfg_type;
endpackage : chlvl_pkg
`default_nettype wire

/* rtl/chlvl_regs.sv */
// Function
// - Source select bits 6:5, zero disables input
// - Volume code bits 7:0, zero mutes
// - Code 1 is -100 dB, 2 is -99.5
// - Code 201 unity, 202 is +0.5 dB
// - Code 254 is +26.5, 255 is +27
// - Volume register 0x43 resets to 0xc9
// - Trim bits 7:4, zero is -0.8 dB
// - Trim 8 is 0 dB, 9 is +0.1
// - Trim 14 is +0.6, 15 is +0.7
// - Trim register resets 0x80, low nibble zero
// - Source register 0x41 resets to 0x00
// - Phase register 0x45 resets to 0x00
// - Phase code delays that many modulator cycles
`default_nettype none
module chlvl_regs
	import chlvl_pkg::*;
#(
	parameter int DELAY_DEPTH = 255
)
(
	input  wire logic          clk_i,
	input  wire logic          reset_i,
	input  wire chlvl_req_type req_i,
	input  wire logic          mod_tick_i,
	input  wire logic          mic_data_i,
	output var  logic [7:0]    rdata_o,
	output var  logic          rvalid_o,
	output var  chlvl_cfg_type cfg_o,
	output var  logic          delayed_data_o
);
	// ***************************************************
	// Parameter check
	// ***************************************************
	// Taps are indexed by the 8-bit code, so a longer line is never reached
	if (DELAY_DEPTH < 2 || DELAY_DEPTH > 255)
	begin : g_depth_check
		$error("delay depth out of range");
	end

	// Fields must fit inside their byte
	if (SOURCE_LSB + 2 > 8 || TRIM_LSB + 4 > 8)
	begin : g_field_check
		$error("field position out of range");
	end

	// ***************************************************
	// Interface timing
	// ***************************************************
	// Writes land on the request edge and read back one cycle later.
	// Read data and its flag follow the read edge by one cycle.
	// Settings reach cfg_o one edge after the register changes,
	// so the signal path never sees a half-written byte.
	// Tick and data are taken as synchronous to clk_i; no sync stage.
	// A read and write in one cycle returns the old value.

	// ***************************************************
	// Registers
	// ***************************************************
	logic [7:0] source_config;
	logic [7:0] volume;
	logic [7:0] gain_trim;
	logic [7:0] phase_delay;

	// ***************************************************
	// Request decode
	// ***************************************************
	// Address compare only; the strobes qualify it below
	wire hit_source = req_i.addr == ADDR_SOURCE_CONFIG;
	wire hit_volume = req_i.addr == ADDR_VOLUME;
	wire hit_trim   = req_i.addr == ADDR_GAIN_TRIM;
	wire hit_phase  = req_i.addr == ADDR_PHASE_DELAY;

	// Read-only bits keep their old value, so stray writes cannot set them
	wire [7:0] next_source = (req_i.wdata & SOURCE_WRITE_MASK)
		| (source_config & ~SOURCE_WRITE_MASK);
	wire [7:0] next_trim   = req_i.wdata & TRIM_WRITE_MASK;

	// ***************************************************
	// Write strobes
	// ***************************************************
	// Unmapped writes match no strobe and are dropped
	wire write_source = req_i.write && hit_source;
	wire write_volume = req_i.write && hit_volume;
	wire write_trim   = req_i.write && hit_trim;
	wire write_phase  = req_i.write && hit_phase;

	// Source select and its reserved bits
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			source_config <= RESET_SOURCE_CONFIG;
		else if (write_source)
			source_config <= next_source;
	end

	// Volume code, full byte
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			volume <= RESET_VOLUME;
		else if (write_volume)
			volume <= req_i.wdata;
	end

	// Trim code; low nibble never stored
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			gain_trim <= RESET_GAIN_TRIM;
		else if (write_trim)
			gain_trim <= next_trim;
	end

	// Phase delay code
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			phase_delay <= RESET_PHASE_DELAY;
		else if (write_phase)
			phase_delay <= req_i.wdata;
	end

	// ***************************************************
	// Read path
	// ***************************************************
	// Unmapped addresses read as zero
	wire [7:0] next_rdata = hit_source ? source_config
		: hit_volume ? volume
		: hit_trim   ? gain_trim
		: hit_phase  ? phase_delay
		: 8'h00;

	wire read_strobe = req_i.read;

	// Answer flag pulses once per accepted read
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			rvalid_o <= 1'b0;
		else
			rvalid_o <= read_strobe;
	end

	// Data holds between reads so a slow reader still sees it
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			rdata_o <= 8'h00;
		else if (read_strobe)
			rdata_o <= next_rdata;
	end

	// ***************************************************
	// Decoded settings
	// ***************************************************
	wire [1:0] source_sel = source_config[SOURCE_LSB +: 2];
	wire [3:0] trim_code  = gain_trim[TRIM_LSB +: 4];
	// Volume dB*10 = (code-201)*5; trim dB*10 = code-8
	wire signed [11:0] vol_tenths  = 12'(($signed({4'h0, volume})
		- $signed({4'h0, VOLUME_UNITY})) * VOLUME_STEP_TENTHS);
	wire signed [11:0] trim_tenths = 12'(($signed({8'h00, trim_code})
		- $signed({8'h00, TRIM_UNITY})) * TRIM_STEP_TENTHS);
	// Codes 1 and 3 count as enabled; software must not use them
	wire next_enable = source_sel != SOURCE_OFF;
	wire next_mute   = (volume == VOLUME_MUTE) || !next_enable;

	chlvl_cfg_type next_cfg;
	assign next_cfg.enable         = next_enable;
	assign next_cfg.mute           = next_mute;
	assign next_cfg.source         = source_sel;
	assign next_cfg.volume         = volume;
	assign next_cfg.trim           = trim_code;
	assign next_cfg.delay          = phase_delay;
	assign next_cfg.gain_tenths_db = next_mute ? 12'sh000 : 12'(vol_tenths + trim_tenths);

	// One register stage keeps every output on a flop
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			cfg_o <= '0;
		else
			cfg_o <= next_cfg;
	end

	// ***************************************************
	// Phase delay line
	// ***************************************************
	// Shift on each modulator tick; tap chosen by code, zero bypasses.
	// A flop chain costs area, but keeps every tap readable in one cycle.
	localparam logic [7:0] LAST_TAP = 8'(DELAY_DEPTH);

	logic [DELAY_DEPTH:1] delay_line;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			delay_line <= '0;
		else if (mod_tick_i)
			delay_line <= {delay_line[DELAY_DEPTH-1:1], mic_data_i};
	end

	// Codes past a shortened line fall back to its last tap
	wire [7:0] tap          = (phase_delay > LAST_TAP) ? LAST_TAP : phase_delay;
	wire       tapped_bit   = delay_line[tap];
	wire       next_delayed = !next_enable ? 1'b0
		: (tap == 8'h00) ? mic_data_i
		: tapped_bit;

	// Disabled channel outputs zero rather than stale line contents
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			delayed_data_o <= 1'b0;
		else
			delayed_data_o <= next_delayed;
	end
endmodule : chlvl_regs
`default_nettype wire

/* tb/chlvl_regs_assertions.sv */
`default_nettype none
module chlvl_chk
	import chlvl_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          reset_i,
	input wire chlvl_req_type req_i,
	input wire logic [7:0]    rdata_o,
	input wire logic          rvalid_o,
	input wire chlvl_cfg_type cfg_o,
	input wire logic          mic_data_i,
	input wire logic          delayed_data_o
);
	default clocking @(posedge clk_i); endclocking
	// Output settles one edge after reset; cfg_o is zero until then
	logic settled = 1'b0;
	always_ff @(posedge clk_i) settled <= !reset_i;
	default disable iff (reset_i);
	sequence rd_taken; req_i.read; endsequence
	sequence rd_answer; ##1 rvalid_o; endsequence
	read_answer_a: assert property (rd_taken |-> rd_answer)
		else $error("read not answered");
	read_quiet_a: assert property (!req_i.read |=> !rvalid_o)
		else $error("stray read answer");
	mute_zero_a: assert property (settled && cfg_o.volume == VOLUME_MUTE |-> cfg_o.mute)
		else $error("code zero not muted");
	source_off_a: assert property (cfg_o.enable == (cfg_o.source != SOURCE_OFF))
		else $error("enable wrong for source");
	gain_law_a: assert property (settled && !cfg_o.mute |-> cfg_o.gain_tenths_db ==
		12'((int'(cfg_o.volume) - 201) * 5 + int'(cfg_o.trim) - 8)) else $error("gain wrong");
	trim_low_a: assert property (rvalid_o && $past(req_i.addr) == ADDR_GAIN_TRIM
		|-> rdata_o[3:0] == 4'h0) else $error("trim low nibble set");
	src_bit_a: assert property (rvalid_o && $past(req_i.addr) == ADDR_SOURCE_CONFIG
		|-> !rdata_o[1]) else $error("source bit one set");
	reset_cfg_a: assert property ($fell(reset_i) |=> cfg_o.volume == RESET_VOLUME
		&& cfg_o.trim == TRIM_UNITY && cfg_o.delay == 8'h00 && !cfg_o.enable)
		else $error("reset decode wrong");
	delay_pass_a: assert property (settled && cfg_o.enable && cfg_o.delay == 8'h00
		|-> delayed_data_o == $past(mic_data_i)) else $error("zero delay not passed");
	off_quiet_a: assert property (settled && !cfg_o.enable |-> !delayed_data_o)
		else $error("disabled channel drives data");
endmodule : chlvl_chk
bind chlvl_regs chlvl_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
	.rdata_o(rdata_o), .rvalid_o(rvalid_o), .cfg_o(cfg_o), .mic_data_i(mic_data_i),
	.delayed_data_o(delayed_data_o));
`default_nettype wire

/* tb/chlvl_regs_tb.sv */
`default_nettype none
module chlvl_regs_tb
	import chlvl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk_i = 0, reset_i = 1, tick = 0, mic = 0, rvalid, dly, pm;
	chlvl_req_type req = '0;
	chlvl_cfg_type cfg;
	logic [7:0]    rdata, v, exp_q[$];
	int            err_total, comparisons, cyc, g;
	localparam logic [7:0] A[5] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h42};
	localparam logic [7:0] R[5] = '{8'h00, 8'hc9, 8'h80, 8'h00, 8'h00};
	localparam logic [7:0] M[5] = '{8'hfd, 8'hff, 8'hf0, 8'hff, 8'h00};
	localparam logic [7:0] V[11] = '{0, 1, 2, 201, 202, 254, 255, 201, 201, 201, 201};
	localparam logic [3:0] T[11] = '{8, 8, 8, 8, 8, 8, 8, 0, 9, 14, 15};
	chlvl_regs DUT (.clk_i(clk_i), .reset_i(reset_i), .req_i(req), .mod_tick_i(tick),
		.mic_data_i(mic), .rdata_o(rdata), .rvalid_o(rvalid), .cfg_o(cfg),
		.delayed_data_o(dly));
	initial forever #10 clk_i = ~clk_i;
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want)
		begin
			err_total++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, want);
		end
	endtask : check
	task automatic end_sim;
		$display("compared %0d, mismatched %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	// Expected read data is queued at the request edge, popped on the answer
	task automatic acc(input logic w, r, input logic [7:0] a, d, e);
		@(posedge clk_i);
		req <= '{w, r, a, d};
		if (r) exp_q.push_back(e);
	endtask : acc
	// ****
	// Monitor
	// ****
	always @(posedge clk_i)
	begin
		cyc++;
		tick <= 1'($urandom);
		mic <= 1'($urandom);
		if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
		if (cyc == 3000)
		begin
			err_total++;
			end_sim();
		end
	end
	initial
	begin
		void'($urandom(32'h53285f02));
		repeat (20) @(posedge clk_i);
		reset_i <= 0;
		for (int i = 0; i < 5; i++) acc(0, 1, A[i], 0, R[i]);
		$display("reset values done");
		for (int i = 0; i < 5; i++)
		begin
			v = 8'($urandom);
			if (i == 0) v = v & 8'h40;
			acc(1, 0, A[i], v, 0);
			acc(0, 1, A[i], 0, v & M[i]);
		end
		$display("write mask done");
		acc(1, 0, ADDR_SOURCE_CONFIG, 8'h40, 0);
		for (int i = 0; i < 11; i++)
		begin
			acc(1, 0, ADDR_VOLUME, V[i], 0);
			acc(1, 0, ADDR_GAIN_TRIM, {T[i], 4'h0}, 0);
			repeat (3) acc(0, 0, 0, 0, 0);
			g = (V[i] == 0) ? 0 : (int'(V[i]) - 201) * 5 + int'(T[i]) - 8;
			check(cfg.gain_tenths_db, 12'(g));
			check(cfg.mute, V[i] == 0);
		end
		$display("gain table done");
		acc(1, 0, ADDR_PHASE_DELAY, 8'h00, 0);
		repeat (3) acc(0, 0, 0, 0, 0);
		for (int i = 0; i < 20; i++)
		begin
			pm = mic;
			@(posedge clk_i);
			check(dly, pm);
		end
		$display("delay pass done");
		reset_i <= 1;
		repeat (3) @(posedge clk_i);
		reset_i <= 0;
		acc(0, 1, ADDR_SOURCE_CONFIG, 0, 8'h00);
		acc(0, 1, ADDR_VOLUME, 0, 8'hc9);
		repeat (3) acc(0, 0, 0, 0, 0);
		check(cfg.enable, 0);
		check(dly, 0);
		$display("second reset done");
		end_sim();
	end
endmodule : chlvl_regs_tb
`default_nettype wire
